// [common/spc_pkg.sv]
// Purpose: Shared constants for the scan pulse counter
// Assumes: 40 MHz logger clock
// Notes:   Times in ns, cycle counts derived from the clock period
package spc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned CNT_W         = 32;
   // Noise filter: samples agreeing before an input level is accepted
   localparam int unsigned FILT_TIME_NS  = 200;
   localparam int unsigned FILT_CYC      = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Contact bounce hold-off after an accepted closure edge
   localparam int unsigned DEB_TIME_NS   = 2000000;
   localparam int unsigned DEB_CYC       = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FILT_W        = 8;
   localparam int unsigned DEB_W         = 20;
   localparam int unsigned DIV_W         = 32;
   localparam logic [CNT_W-1:0] CNT_RST  = 32'h0000_0000;
   typedef enum logic [2:0] {
      SPC_IDLE = 3'b001,
      SPC_RUN  = 3'b010,
      SPC_DONE = 3'b100
   } spc_div_t;
endpackage

// [hdl/spc_freq_div.sv]
// Purpose: Sequential divider turning a scan count into hertz
// Assumes: Scan length given in clock cycles, nonzero
// Notes:   One quotient bit per cycle; restarts on each start pulse
module spc_freq_div #(
   parameter int unsigned W = 32
) (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst,
   // Request
   input  wire logic          start,
   input  wire logic [W-1:0]  count,
   input  wire logic [W-1:0]  scan_cycles,
   // Answer
   output logic [W-1:0]       freq_hz,
   output logic               freq_valid
);
   import spc_pkg::*;
   // Clock rate in hertz, from the clock period
   localparam logic [63:0] HZ_SCALE = 64'(1000000000 / CLK_PERIOD_NS);
   if (W < 8 || W > 32) begin
      $error("spc_freq_div: W out of range");
   end
   typedef struct packed {
      spc_div_t     st;
      logic [63:0]  num;
      logic [63:0]  rem;
      logic [W-1:0] den;
      logic [W-1:0] quo;
      logic [6:0]   step;
      logic [W-1:0] freq;
      logic         vld;
   } spc_div_state_t;
   spc_div_state_t s_r, s_nxt;
   always_comb begin
      logic [63:0] trial;
      trial = 64'h0;
      s_nxt = s_r;
      s_nxt.vld = 1'b0;
      case (s_r.st)
         SPC_IDLE, SPC_DONE: begin
            s_nxt.st = SPC_IDLE;
         end
         SPC_RUN: begin
            // Rate = count * clock_hz / scan_cycles, long division
            trial = {s_r.rem[62:0], s_r.num[63]};
            s_nxt.num = {s_r.num[62:0], 1'b0};
            if (trial >= {32'h0, s_r.den}) begin
               s_nxt.rem = trial - {32'h0, s_r.den};
               s_nxt.quo = {s_r.quo[W-2:0], 1'b1};
            end else begin
               s_nxt.rem = trial;
               s_nxt.quo = {s_r.quo[W-2:0], 1'b0};
            end
            s_nxt.step = s_r.step - 7'h01;
            if (s_r.step == 7'h01) begin
               s_nxt.st   = SPC_DONE;
               s_nxt.freq = s_nxt.quo;
               s_nxt.vld  = 1'b1;
            end
         end
         default: s_nxt.st = SPC_IDLE;
      endcase
      if (start) begin
         s_nxt.st   = SPC_RUN;
         s_nxt.num  = {32'h0, count} * HZ_SCALE;
         s_nxt.rem  = 64'h0;
         s_nxt.den  = (scan_cycles == '0) ? W'(1) : scan_cycles;
         s_nxt.quo  = '0;
         s_nxt.step = 7'd64;
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         s_r <= '{st: SPC_IDLE, num: 64'h0, rem: 64'h0, den: '0, quo: '0,
                  step: 7'h00, freq: '0, vld: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end
   assign freq_hz    = s_r.freq;
   assign freq_valid = s_r.vld;
endmodule

// [hdl/spc_scan_pulse_counter.sv]
// Purpose: Per-terminal pulse accumulator read and cleared each scan
// Assumes: pulse_in is asynchronous; scan_start is a one-cycle strobe
// Notes:   Frequency result follows the count 65 cycles later
module spc_scan_pulse_counter #(
   parameter int unsigned FILT_CYCLES = spc_pkg::FILT_CYC,
   parameter int unsigned DEB_CYCLES  = spc_pkg::DEB_CYC
) (
   // Clock and reset
   input  wire logic                         clock,
   input  wire logic                         rst,
   // Terminal and configuration
   input  wire logic                         pulse_in,
   input  wire logic                         enable,
   input  wire logic                         closure_mode,
   input  wire logic                         count_falling,
   // Scan timing
   input  wire logic                         scan_start,
   input  wire logic [spc_pkg::DIV_W-1:0]    scan_cycles,
   // Results
   output logic [spc_pkg::CNT_W-1:0]         count_out,
   output logic                              count_valid,
   output logic [spc_pkg::CNT_W-1:0]         freq_hz,
   output logic                              freq_valid,
   output logic [spc_pkg::CNT_W-1:0]         live_count
);
   import spc_pkg::*;
   if (FILT_CYCLES < 1 || FILT_CYCLES >= (1 << FILT_W)) begin
      $error("spc_scan_pulse_counter: FILT_CYCLES out of range");
   end
   if (DEB_CYCLES < 1 || DEB_CYCLES >= (1 << DEB_W)) begin
      $error("spc_scan_pulse_counter: DEB_CYCLES out of range");
   end
   localparam logic [FILT_W-1:0] FILT_LIM = FILT_W'(FILT_CYCLES);
   localparam logic [DEB_W-1:0]  DEB_LIM  = DEB_W'(DEB_CYCLES);

   typedef struct packed {
      logic              sync1;
      logic              sync2;
      logic [FILT_W-1:0] filt_cnt;
      logic              level;
      logic [DEB_W-1:0]  deb_cnt;
      logic [CNT_W-1:0]  acc;
      logic [CNT_W-1:0]  result;
      logic              rvld;
      logic              div_go;
   } spc_state_t;

   spc_state_t s_r, s_nxt;
   logic       edge_hit;

   always_comb begin
      logic filt_lvl;
      logic rise;
      logic fall;
      filt_lvl = s_r.level;
      rise     = 1'b0;
      fall     = 1'b0;
      edge_hit = 1'b0;
      s_nxt    = s_r;
      s_nxt.sync1  = pulse_in;
      s_nxt.sync2  = s_r.sync1;
      s_nxt.rvld   = 1'b0;
      s_nxt.div_go = 1'b0;
      // Short glitches never reach the detector
      if (s_r.sync2 == s_r.level) begin
         s_nxt.filt_cnt = '0;
      end else if (s_r.filt_cnt >= FILT_LIM - 1'b1) begin
         s_nxt.filt_cnt = '0;
         s_nxt.level    = s_r.sync2;
         filt_lvl       = s_r.sync2;
      end else begin
         s_nxt.filt_cnt = s_r.filt_cnt + 1'b1;
      end
      rise = filt_lvl & ~s_r.level;
      fall = ~filt_lvl & s_r.level;
      // Hold-off after a closure swallows bounce
      if (s_r.deb_cnt != '0) begin
         s_nxt.deb_cnt = s_r.deb_cnt - 1'b1;
      end
      if (enable && (count_falling ? fall : rise)) begin
         if (!closure_mode) begin
            edge_hit = 1'b1;
         end else if (s_r.deb_cnt == '0) begin
            edge_hit      = 1'b1;
            s_nxt.deb_cnt = DEB_LIM;
         end
      end
      // Rising or falling edges alike restart the hold-off while bouncing
      if (closure_mode && (rise || fall) && s_r.deb_cnt != '0) begin
         s_nxt.deb_cnt = DEB_LIM;
      end
      // Plain wrap at 2^32, no saturation
      if (edge_hit) begin
         s_nxt.acc = s_r.acc + 1'b1;
      end
      // Same-cycle capture and restart; an edge now opens the new scan
      if (scan_start) begin
         s_nxt.result = s_r.acc;
         s_nxt.acc    = edge_hit ? CNT_W'(1) : CNT_RST;
         s_nxt.rvld   = 1'b1;
         s_nxt.div_go = 1'b1;
      end
      if (!enable) begin
         s_nxt.deb_cnt = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_r <= '{sync1: 1'b0, sync2: 1'b0, filt_cnt: '0, level: 1'b0,
                  deb_cnt: '0, acc: CNT_RST, result: CNT_RST, rvld: 1'b0,
                  div_go: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Frequency from the just-captured count
   spc_freq_div #(
      .W (CNT_W)
   ) u_div (
      .clock       (clock),
      .rst         (rst),
      .start       (s_r.div_go),
      .count       (s_r.result),
      .scan_cycles (scan_cycles),
      .freq_hz     (freq_hz),
      .freq_valid  (freq_valid)
   );

   assign count_out   = s_r.result;
   assign count_valid = s_r.rvld;
   assign live_count  = s_r.acc;
endmodule

// [testbench/spc_scan_pulse_counter_properties.sv]
// Purpose: Port checks for the scan pulse counter
// Assumes: One clock, synchronous reset
// Notes:   Counter below measures cycles since scan start
module spc_chk (
   // Clock and reset
   input wire logic                      clock,
   input wire logic                      rst,
   // Inputs
   input wire logic                      enable,
   input wire logic                      scan_start,
   input wire logic [spc_pkg::DIV_W-1:0] scan_cycles,
   // Results
   input wire logic [spc_pkg::CNT_W-1:0] count_out,
   input wire logic                      count_valid,
   input wire logic [spc_pkg::CNT_W-1:0] freq_hz,
   input wire logic                      freq_valid,
   input wire logic [spc_pkg::CNT_W-1:0] live_count
);
   import spc_pkg::*;
   typedef struct packed {logic [7:0] since;} spc_chk_t;
   spc_chk_t st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      if (scan_start) st_nxt.since = 8'h01;
      else if (st_r.since != 8'hff) st_nxt.since = st_r.since + 8'h01;
   end
   always_ff @(posedge clock) begin
      if (rst) st_r <= 8'hff;
      else st_r <= st_nxt;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_valid_follows: assert property (scan_start |=> count_valid)
      else $error("count_valid late");
   a_valid_cause: assert property (count_valid |-> $past(scan_start))
      else $error("count_valid without scan start");
   a_capture_value: assert property (scan_start |=> count_out == $past(live_count))
      else $error("count_out not the accumulator");
   a_clear_start: assert property (scan_start |=> live_count <= 32'h1)
      else $error("live_count not cleared");
   a_step_one: assert property (!scan_start |=> live_count == $past(live_count) ||
      live_count == $past(live_count) + 32'h1) else $error("count step not one");
   a_hold_disabled: assert property ((!enable && !scan_start)[*2] |=> $stable(live_count))
      else $error("count while disabled");
   a_freq_due: assert property (st_r.since == 8'h42 |-> freq_valid)
      else $error("freq_valid late");
   a_freq_cause: assert property (freq_valid |-> st_r.since == 8'h42)
      else $error("freq_valid untimely");
   a_freq_value: assert property (freq_valid |-> freq_hz == 32'((64'(count_out) *
      64'd40000000) / (scan_cycles == 32'h0 ? 64'h1 : 64'(scan_cycles))))
      else $error("freq_hz wrong");
   c_counted: cover property (count_valid && count_out > 32'h1);
   c_freq: cover property (freq_valid);
   c_off: cover property (scan_start && !enable);
endmodule

bind spc_scan_pulse_counter spc_chk u_chk (.clock, .rst, .enable, .scan_start, .scan_cycles,
   .count_out, .count_valid, .freq_hz, .freq_valid, .live_count);

// [testbench/spc_sensor_model.sv]
// Purpose: Pulse-output sensor on one terminal
// Assumes: Line rests at its pull level between bursts
// Notes:   Glitch and bounce shapes on request
module spc_sensor_model (
   // Clock
   input wire logic clock,
   // Sensor line
   output logic     pulse_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic idle = 1'b0;
   initial pulse_out = 1'b0;
   task automatic pulse(input int w);
      @(posedge clock) #2 pulse_out = !idle;
      repeat (w) @(posedge clock);
      #2 pulse_out = idle;
      repeat (w) @(posedge clock);
   endtask
   // Mode 1 adds a one-cycle glitch, mode 2 contact bounce
   task automatic burst(input int n, input int w, input int mode, input logic lvl);
      idle = lvl;
      @(posedge clock) #2 pulse_out = idle;
      repeat (8) @(posedge clock);
      repeat (n) begin
         if (mode == 1) pulse(1);
         if (mode == 2) repeat (2) pulse(4);
         pulse(w);
      end
   endtask
endmodule

// [testbench/tb.sv]
// Purpose: Self-checking bench for the scan pulse counter
// Assumes: Shortened filter and debounce counts
// Notes:   One terminal only, so no pair conflict arises
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 0, rst = 1, enable = 1, closure_mode = 0, count_falling = 0, scan_start = 0;
   logic [31:0] scan_cycles = 32'h64, lfsr = 32'h7792f39d, count_out, freq_hz, live_count;
   logic count_valid, freq_valid, pulse_in;
   logic [31:0] qc[$], qf[$];
   int miscompares = 0, cmp_count = 0;
   always #12.5 clock = ~clock;
   spc_scan_pulse_counter #(.FILT_CYCLES(2), .DEB_CYCLES(20)) dut (.clock, .rst, .pulse_in,
      .enable, .closure_mode, .count_falling, .scan_start, .scan_cycles, .count_out,
      .count_valid, .freq_hz, .freq_valid, .live_count);
   // Only this terminal is configured; its pair partner stays unused
   spc_sensor_model sens (.clock, .pulse_out(pulse_in));
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Closes the interval holding n pulses
   task automatic scan(input logic [31:0] n);
      logic [63:0] d;
      d = (scan_cycles == 32'h0) ? 64'h1 : 64'(scan_cycles);
      qc.push_back(n);
      qf.push_back(32'((64'(n) * 64'd40000000) / d));
      repeat (10) @(posedge clock);
      #2 scan_start = 1;
      @(posedge clock) #2 scan_start = 0;
      repeat (70) @(posedge clock);
   endtask
   always @(posedge clock) begin
      #1;
      if (count_valid === 1'b1) chk("count_out", qc.pop_front(), count_out);
      if (freq_valid === 1'b1) chk("freq_hz", qf.pop_front(), freq_hz);
   end
   initial begin
      logic [31:0] n;
      repeat (2) @(posedge clock);
      #2 rst = 0;
      scan(0);
      for (int i = 0; i < 12; i++) begin
         #2 closure_mode = i[1];
         count_falling = i[0];
         scan_cycles = (i == 0) ? 32'h0 : rnd() % 32'd1000 + 32'd1;
         n = rnd() % 32'd8 + 32'd1;
         sens.burst(n, closure_mode ? 40 : 4 + rnd() % 4, closure_mode ? 2 : i[2], i[0]);
         scan(n);
      end
      // Edge accepted in the capture cycle belongs to the new scan
      #2 closure_mode = 0;
      count_falling = 0;
      sens.burst(0, 4, 0, 1'b0);
      qc.push_back(32'h0);
      qf.push_back(32'h0);
      fork
         sens.pulse(8);
         begin
            repeat (4) @(posedge clock);
            #2 scan_start = 1;
            @(posedge clock) #2 scan_start = 0;
            chk("live_count", 32'h1, live_count);
         end
      join
      repeat (70) @(posedge clock);
      scan(32'h1);
      #2 enable = 0;
      sens.burst(3, 4, 0, 1'b0);
      scan(0);
      end_sim();
   end
   initial begin
      #2ms;
      miscompares++;
      end_sim();
   end
endmodule
